// [idguard_pkg.sv]
// shared constants and types for the id authentication and write guard
package idguard_pkg;
    localparam int ADDR_W = 16;
    // register byte offsets
    localparam logic [15:0] OFS_STATUS_FIRST = 16'h01FC;
    localparam logic [15:0] OFS_STATUS_SECOND = 16'h03FC;
    localparam logic [15:0] OFS_CUST_IN = 16'h0100;
    localparam logic [15:0] OFS_TEST_IN = 16'h0060;
    localparam logic [15:0] OFS_DEBUG_IN = 16'h0040;
    localparam logic [15:0] OFS_DATA_IN = 16'h0020;
    localparam logic [15:0] OFS_SERIAL_IN = 16'h0000;
    localparam logic [15:0] OFS_HSIF_IN = 16'h0200;
    localparam logic [15:0] OFS_WE_A = 16'h3800;
    localparam logic [15:0] OFS_WE_B = 16'h3804;
    localparam logic [15:0] OFS_IRQ_STATUS = 16'h3810;
    localparam logic [15:0] OFS_IRQ_MASK = 16'h3814;
    localparam logic [15:0] OFS_GUARD_ERR = 16'h3818;
    // word 0 holds id bits 31:0, word 7 bits 255:224
    localparam int NWORDS = 8;
    localparam int NGROUPS = 6;
    // group index: 0 serial, 1 data, 2 debug, 3 test, 4 customer, 5 hsif
    localparam int GRP_HSIF = 5;
    localparam logic [31:0] WE_RESET = 32'h0000_0000;
    localparam int WE_BIT = 0;
    // event bits in the interrupt status register
    localparam int EV_GUARD_ERR = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_W = 2;

    typedef enum logic [3:0] {
        CMD_PROGRAM, CMD_MULTI_PROGRAM, CMD_DMA_PROGRAM, CMD_BLOCK_ERASE,
        CMD_AREA_ERASE, CMD_BLANK_CHECK, CMD_SUSPEND, CMD_RESUME,
        CMD_CONFIG_SET, CMD_PROTECT_SET, CMD_SECURITY_SET,
        CMD_STATUS_CLEAR, CMD_FORCED_STOP
    } flash_cmd_t;

    typedef struct packed {
        logic valid;
        flash_cmd_t cmd;
    } cmd_req_t;

    typedef struct packed {
        logic valid;
        logic refused;
    } cmd_ans_t;
endpackage : idguard_pkg

// [id_auth_and_flash_write_guard.sv]
// id authentication status and flash program/erase write guard
// What this block does
// RULE1: bit 4 shows customer id lock
// RULE2: bit 3 shows test mode id lock
// RULE3: bit 2 shows debug id lock
// RULE4: bit 1 shows data store id lock
// RULE5: bit 0 shows serial programming id lock
// RULE6: hsif id compared against eight input words
// RULE7: software writes input words in ascending order
// RULE8: reference id comes from security settings area
// RULE9: second status bit 0 hsif lock, rest zero
// RULE10: software sets both enables before program/erase
// RULE11: guarded commands refused while enables are zero
// RULE12: refused command sets guard error flag
// RULE13: enable b bit 0 read/write, resets zero
// RULE14: enable a bit 0 read/write, resets zero
// RULE15: enable bits 31 to 1 read zero
// RULE16: software uses 32-bit enable accesses only
// RULE17: reset value from all-ones/all-zeros reference id
// RULE18: status updates after eighth ordered word written
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module id_auth_and_flash_write_guard (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [idguard_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [idguard_pkg::NGROUPS*256-1:0] ref_ids_i,
    input wire logic ref_load_i,
    input wire idguard_pkg::cmd_req_t cmd_req_i,
    output idguard_pkg::cmd_ans_t cmd_ans_o,
    output logic write_guard_error_flag_o,
    input wire logic guard_err_clear_i,
    output logic irq_o
);
    import idguard_pkg::*;

    // input words and ordered-write progress per group
    logic [255:0] in_words_q [NGROUPS];
    logic [3:0] next_idx_q [NGROUPS];
    logic [NGROUPS-1:0] lock_q;
    logic [NGROUPS-1:0] lock_d;
    logic [255:0] ref_q [NGROUPS];
    logic ref_valid_q;
    logic write_enable_a_bit_q;
    logic write_enable_b_bit_q;
    logic guard_err_q;
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_mask_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdata_q;
    logic irq_q;
    cmd_ans_t ans_q;

    wire logic req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire logic full_word = (wb_sel_i == 4'hF);
    wire logic wr = req && wb_we_i && full_word;
    wire logic [15:0] adr = wb_adr_i;

    function automatic logic [15:0] grp_base(input int g);
        case (g)
            0: grp_base = OFS_SERIAL_IN;
            1: grp_base = OFS_DATA_IN;
            2: grp_base = OFS_DEBUG_IN;
            3: grp_base = OFS_TEST_IN;
            4: grp_base = OFS_CUST_IN;
            default: grp_base = OFS_HSIF_IN;
        endcase
    endfunction : grp_base

    function automatic logic in_grp(input logic [15:0] a, input int g);
        logic [15:0] base;
        base = grp_base(g);
        in_grp = (a[15:5] == base[15:5]) && (a[1:0] == 2'b00);
    endfunction : in_grp

    // lock is clear when the reference is all ones, else on exact match
    function automatic logic calc_lock(input logic [255:0] r,
                                       input logic [255:0] w);
        calc_lock = !((&r) || (r == w));
    endfunction : calc_lock

    logic [NGROUPS-1:0] grp_hit;
    logic [NGROUPS-1:0] grp_done;
    genvar g;
    generate
        for (g = 0; g < NGROUPS; g++) begin : gen_grp
            wire logic [2:0] widx = adr[4:2];
            assign grp_hit[g] = in_grp(adr, g);
            // RULE7 RULE18 ordered eighth word
            assign grp_done[g] = wr && grp_hit[g]
                && ({1'b0, widx} == next_idx_q[g]) && (widx == 3'd7);
            // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 compare full id
            always_comb begin
                lock_d[g] = lock_q[g];
                if (grp_done[g]) begin
                    lock_d[g] = calc_lock(ref_q[g],
                        {wb_dat_i, in_words_q[g][223:0]});
                end else if (&ref_q[g]) begin
                    lock_d[g] = 1'b0;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    in_words_q[g] <= '0;
                    next_idx_q[g] <= 4'h0;
                end else if (wr && grp_hit[g]) begin
                    in_words_q[g][widx*32 +: 32] <= wb_dat_i;
                    if ({1'b0, widx} == next_idx_q[g]) begin
                        next_idx_q[g] <= (widx == 3'd7) ? 4'h0
                                       : next_idx_q[g] + 4'h1;
                    end else begin
                        next_idx_q[g] <= (widx == 3'd0) ? 4'h1 : 4'h0;
                    end
                end
            end
        end
    endgenerate

    // RULE8 reference from security area
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_valid_q <= 1'b0;
        end else if (ref_load_i) begin
            ref_valid_q <= 1'b1;
        end
    end
    generate
        for (g = 0; g < NGROUPS; g++) begin : gen_ref
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ref_q[g] <= '0;
                end else if (ref_load_i) begin
                    ref_q[g] <= ref_ids_i[g*256 +: 256];
                end
            end
        end
    endgenerate

    // RULE17 initial lock from reference pattern
    wire logic [NGROUPS-1:0] init_lock;
    generate
        for (g = 0; g < NGROUPS; g++) begin : gen_init
            assign init_lock[g] = !((&ref_ids_i[g*256 +: 256])
                || (ref_ids_i[g*256 +: 256] == 256'h0));
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_q <= '0;
        end else if (ref_load_i && !ref_valid_q) begin
            lock_q <= init_lock;
        end else begin
            lock_q <= lock_d;
        end
    end

    // RULE11 guarded command set
    function automatic logic is_guarded(input flash_cmd_t c);
        is_guarded = (c != CMD_STATUS_CLEAR) && (c != CMD_FORCED_STOP);
    endfunction : is_guarded

    wire logic both_en = write_enable_a_bit_q && write_enable_b_bit_q;
    wire logic refuse = cmd_req_i.valid && is_guarded(cmd_req_i.cmd)
        && !both_en;
    wire logic any_unlock = |(lock_q & ~lock_d);

    // RULE13 RULE14 enable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_enable_a_bit_q <= WE_RESET[WE_BIT];
            write_enable_b_bit_q <= WE_RESET[WE_BIT];
        end else if (wr && adr == OFS_WE_A) begin
            write_enable_a_bit_q <= wb_dat_i[WE_BIT];
        end else if (wr && adr == OFS_WE_B) begin
            write_enable_b_bit_q <= wb_dat_i[WE_BIT];
        end
    end

    // RULE12 error flag, set wins over clear
    wire logic err_clr = guard_err_clear_i
        || (wr && adr == OFS_GUARD_ERR && wb_dat_i[0]);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guard_err_q <= 1'b0;
        end else if (refuse) begin
            guard_err_q <= 1'b1;
        end else if (err_clr) begin
            guard_err_q <= 1'b0;
        end
    end

    // RULE11 command answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ans_q <= '0;
        end else begin
            ans_q.valid <= cmd_req_i.valid;
            ans_q.refused <= refuse;
        end
    end

    // sticky interrupt events, write one to clear
    wire logic [EV_W-1:0] ev_set = {any_unlock, refuse};
    wire logic [EV_W-1:0] ev_clr = (wr && adr == OFS_IRQ_STATUS)
        ? wb_dat_i[EV_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= ev_set | (irq_stat_q & ~ev_clr);
            if (wr && adr == OFS_IRQ_MASK) begin
                irq_mask_q <= wb_dat_i[EV_W-1:0];
            end
            irq_q <= |((ev_set | (irq_stat_q & ~ev_clr)) & irq_mask_q);
        end
    end

    // read mux; RULE9 RULE15 upper bits read zero
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (adr == OFS_STATUS_FIRST) begin
            rd_mux = {27'h0, lock_q[4:0]};
        end else if (adr == OFS_STATUS_SECOND) begin
            rd_mux = {31'h0, lock_q[GRP_HSIF]};
        end else if (adr == OFS_WE_A) begin
            rd_mux = {31'h0, write_enable_a_bit_q};
        end else if (adr == OFS_WE_B) begin
            rd_mux = {31'h0, write_enable_b_bit_q};
        end else if (adr == OFS_IRQ_STATUS) begin
            rd_mux = {30'h0, irq_stat_q};
        end else if (adr == OFS_IRQ_MASK) begin
            rd_mux = {30'h0, irq_mask_q};
        end else if (adr == OFS_GUARD_ERR) begin
            rd_mux = {31'h0, guard_err_q};
        end else if (|grp_hit) begin
            rd_mux = 32'h0000_0000;
            for (int i = 0; i < NGROUPS; i++) begin
                if (grp_hit[i]) begin
                    rd_mux = in_words_q[i][adr[4:2]*32 +: 32];
                end
            end
        end else begin
            rd_hit = 1'b0;
        end
    end

    // write-only or read-only mismatches are still acked; unmapped errs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && rd_hit;
            err_q <= req && !rd_hit;
            rdata_q <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;
    assign cmd_ans_o = ans_q;
    assign write_guard_error_flag_o = guard_err_q;
    assign irq_o = irq_q;

    // bus answer: one pulse of ack or err, then quiet
    sequence bus_take_s;
        req;
    endsequence
    sequence bus_answer_s;
        (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    answer_once_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        bus_take_s |=> bus_answer_s)
        else $error("bus answer not a single pulse");
    // RULE12 refusal raises flag
    refuse_sets_a: assert property ( // RULE12
        @(posedge clk_i) disable iff (rst_i)
        refuse |=> guard_err_q && ans_q.refused)
        else $error("refused command did not set error flag");
    // RULE12 clear drops flag
    guard_clear_a: assert property ( // RULE12
        @(posedge clk_i) disable iff (rst_i)
        (err_clr && !refuse) |=> !guard_err_q)
        else $error("error flag not cleared");
    // RULE11 enabled commands pass
    enabled_pass_a: assert property ( // RULE11
        @(posedge clk_i) disable iff (rst_i)
        (cmd_req_i.valid && both_en) |=> !ans_q.refused)
        else $error("command refused while enabled");
    // RULE11 unguarded commands pass
    free_cmd_a: assert property ( // RULE11
        @(posedge clk_i) disable iff (rst_i)
        (cmd_req_i.valid && !is_guarded(cmd_req_i.cmd))
        |=> ans_q.valid && !ans_q.refused)
        else $error("unguarded command refused");
    // RULE14 enable a write
    enable_a_wr_a: assert property ( // RULE14
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr == OFS_WE_A)
        |=> write_enable_a_bit_q == $past(wb_dat_i[0]))
        else $error("enable a not written");
    // RULE13 enable b write
    enable_b_wr_a: assert property ( // RULE13
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr == OFS_WE_B)
        |=> write_enable_b_bit_q == $past(wb_dat_i[0]))
        else $error("enable b not written");
    // RULE15 enable upper bits zero
    we_upper_a: assert property ( // RULE15
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && (adr == OFS_WE_A || adr == OFS_WE_B))
        |=> wb_dat_o[31:1] == 31'h0)
        else $error("enable upper bits not zero");
    // RULE9 second status read
    status_two_a: assert property ( // RULE9
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && adr == OFS_STATUS_SECOND)
        |=> wb_ack_o && wb_dat_o[31:1] == 31'h0)
        else $error("second status upper bits not zero");
    // RULE9 second status lock bit
    hsif_bit_a: assert property ( // RULE9
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && adr == OFS_STATUS_SECOND)
        |=> wb_dat_o[0] == $past(lock_q[GRP_HSIF]))
        else $error("second status lock bit wrong");
    // RULE18 eighth word updates
    hsif_done_a: assert property ( // RULE18
        @(posedge clk_i) disable iff (rst_i)
        grp_done[GRP_HSIF] |=> lock_q[GRP_HSIF] == calc_lock(
            ref_q[GRP_HSIF], in_words_q[GRP_HSIF]))
        else $error("hsif status not updated");
    // RULE7 RULE18 other writes hold status
    order_hold_a: assert property ( // RULE7 RULE18
        @(posedge clk_i) disable iff (rst_i)
        (wr && grp_hit[GRP_HSIF] && !grp_done[GRP_HSIF] && !ref_load_i
            && !(&ref_q[GRP_HSIF]))
        |=> $stable(lock_q[GRP_HSIF]))
        else $error("hsif status changed before eighth word");
    // RULE17 all-ones customer reference never locks
    ones_open_a: assert property ( // RULE17
        @(posedge clk_i) disable iff (rst_i)
        (ref_valid_q && &ref_q[4]) |=> !lock_q[4])
        else $error("all-ones reference locked");
    // RULE1 customer status bit
    cust_bit_a: assert property ( // RULE1
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && adr == OFS_STATUS_FIRST)
        |=> wb_dat_o[4] == $past(lock_q[4]))
        else $error("customer status bit wrong");
    // RULE1 first status upper bits zero
    first_upper_a: assert property ( // RULE1
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && adr == OFS_STATUS_FIRST)
        |=> wb_dat_o[31:5] == 27'h0)
        else $error("first status upper bits not zero");
    // RULE2 RULE3 RULE4 RULE5 low status bits
    low_bits_a: assert property ( // RULE2 RULE3 RULE4 RULE5
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && adr == OFS_STATUS_FIRST)
        |=> wb_dat_o[3:0] == $past(lock_q[3:0]))
        else $error("first status low bits wrong");
    // masked events keep the interrupt low
    mask_quiet_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (irq_mask_q == '0) |=> !irq_o)
        else $error("interrupt raised while fully masked");
endmodule : id_auth_and_flash_write_guard

// [id_auth_and_flash_write_guard_tb_top.sv]
// self-checking testbench for the id authentication and write guard
`timescale 1ns/1ns
module id_auth_and_flash_write_guard_tb_top;
    import idguard_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADDR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic wb_err;
    logic [NGROUPS*256-1:0] ref_ids = '0;
    logic ref_load = 1'b0;
    cmd_req_t cmd_req = '0;
    cmd_ans_t cmd_ans;
    logic guard_flag;
    logic err_clear = 1'b0;
    logic irq;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    logic i0;
    logic [255:0] hsif_id;

    id_auth_and_flash_write_guard u_id_auth_and_flash_write_guard (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .wb_err_o(wb_err), .ref_ids_i(ref_ids), .ref_load_i(ref_load),
        .cmd_req_i(cmd_req), .cmd_ans_o(cmd_ans),
        .write_guard_error_flag_o(guard_flag),
        .guard_err_clear_i(err_clear), .irq_o(irq)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // hang guard, well above the length of the whole sequence
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one classic cycle, held until ack or err is sampled high
    task wb_xfer(input logic we, input logic [15:0] a, input logic [31:0] d,
                 input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= sel;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
        end while (!(wb_ack === 1'b1 || wb_err === 1'b1));
        rd = wb_rdat;
        er = wb_err;
        check("single answer", {31'h0, wb_ack ^ wb_err}, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_xfer

    task wr(input logic [15:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, 4'hF);
    endtask : wr

    task rd_chk(input string what, input logic [15:0] a,
                input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0, 4'hF);
        check(what, rd, exp);
    endtask : rd_chk

    function automatic logic [255:0] mk(input logic [31:0] b);
        logic [255:0] v;
        for (int n = 0; n < 8; n++) v[32*n +: 32] = b + 32'(n);
        return v;
    endfunction : mk

    task write_id(input logic [15:0] base, input logic [255:0] id);
        for (int n = 0; n < NWORDS; n++) wr(base + 16'(4*n), id[32*n +: 32]);
    endtask : write_id

    task send_cmd(input flash_cmd_t c, input logic exp);
        @(posedge clk_i);
        cmd_req <= '{valid: 1'b1, cmd: c};
        @(posedge clk_i);
        cmd_req <= '{valid: 1'b0, cmd: c};
        @(posedge clk_i);
        check("answer valid", cmd_ans.valid, 1'b1);
        check("refused", cmd_ans.refused, exp);
    endtask : send_cmd

    task t_reset();
        rd_chk("enable a reset", OFS_WE_A, WE_RESET);
        rd_chk("enable b reset", OFS_WE_B, WE_RESET);
        rd_chk("status first before load", OFS_STATUS_FIRST, 32'h0);
        check("flag reset", guard_flag, 1'b0);
    endtask : t_reset

    task t_enable_regs();
        wr(OFS_WE_A, 32'hFFFF_FFFF);
        rd_chk("enable a set", OFS_WE_A, 32'h1);
        wr(OFS_WE_B, 32'hFFFF_FFFF);
        rd_chk("enable b set", OFS_WE_B, 32'h1);
        wr(OFS_WE_A, 32'h0);
        wb_xfer(1'b1, OFS_WE_A, 32'h1, 4'h1);
        rd_chk("enable a partial write", OFS_WE_A, 32'h0);
        wr(OFS_WE_B, 32'h0);
        rd_chk("enable b clear", OFS_WE_B, 32'h0);
    endtask : t_enable_regs

    task t_guard();
        for (int i = 0; i <= int'(CMD_FORCED_STOP); i++)
            send_cmd(flash_cmd_t'(i), i <= int'(CMD_SECURITY_SET));
        check("flag after refusals", guard_flag, 1'b1);
        rd_chk("error reg set", OFS_GUARD_ERR, 32'h1);
        wr(OFS_GUARD_ERR, 32'h1);
        rd_chk("error reg cleared", OFS_GUARD_ERR, 32'h0);
        wr(OFS_WE_A, 32'h1);
        send_cmd(CMD_BLOCK_ERASE, 1'b1);
        wr(OFS_WE_B, 32'h1);
        for (int i = 0; i <= int'(CMD_FORCED_STOP); i++)
            send_cmd(flash_cmd_t'(i), 1'b0);
        wr(OFS_WE_A, 32'h0);
        check("flag only one enable", guard_flag, 1'b1);
        @(posedge clk_i);
        err_clear <= 1'b1;
        @(posedge clk_i);
        err_clear <= 1'b0;
        @(posedge clk_i);
        check("flag clear pulse", guard_flag, 1'b0);
        send_cmd(CMD_PROGRAM, 1'b1);
        check("flag set again", guard_flag, 1'b1);
        wr(OFS_WE_B, 32'h0);
    endtask : t_guard

    task t_ids();
        hsif_id = mk(32'h1357_9B00);
        ref_ids[0 +: 256] <= '0;
        ref_ids[256 +: 256] <= mk(32'h5A5A_0010);
        ref_ids[512 +: 256] <= mk(32'h0F0F_1200);
        ref_ids[768 +: 256] <= mk(32'h2468_AC00);
        ref_ids[1024 +: 256] <= '1;
        ref_ids[GRP_HSIF*256 +: 256] <= hsif_id;
        @(posedge clk_i);
        ref_load <= 1'b1;
        @(posedge clk_i);
        ref_load <= 1'b0;
        rd_chk("status first loaded", OFS_STATUS_FIRST, 32'hE);
        rd_chk("status second loaded", OFS_STATUS_SECOND, 32'h1);
        write_id(OFS_HSIF_IN, hsif_id);
        rd_chk("hsif match", OFS_STATUS_SECOND,
            32'h0);
        rd_chk("unlock event", OFS_IRQ_STATUS, 32'h3);
        write_id(OFS_HSIF_IN, hsif_id ^ {1'b1, 255'h0});
        rd_chk("hsif top bit wrong", OFS_STATUS_SECOND, 32'h1);
        for (int n = 0; n < 6; n++)
            wr(OFS_HSIF_IN + 16'(4*n), hsif_id[32*n +: 32]);
        wr(OFS_HSIF_IN + 16'h1C, hsif_id[224 +: 32]);
        wr(OFS_HSIF_IN + 16'h18, hsif_id[192 +: 32]);
        rd_chk("hsif out of order", OFS_STATUS_SECOND, 32'h1);
        wr(OFS_STATUS_SECOND, 32'hFFFF_FFFE);
        rd_chk("status second read only", OFS_STATUS_SECOND, 32'h1);
        write_id(OFS_TEST_IN, mk(32'h2468_AC00));
        write_id(OFS_DEBUG_IN, mk(32'h0F0F_1201));
        write_id(OFS_DATA_IN, mk(32'h5A5A_0010));
        write_id(OFS_CUST_IN, 256'h0);
        rd_chk("status first", OFS_STATUS_FIRST,
            32'h4);
    endtask : t_ids

    task t_irq();
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_IRQ_STATUS, 32'h3);
        send_cmd(CMD_AREA_ERASE, 1'b1);
        rd_chk("irq status refusal", OFS_IRQ_STATUS, 32'h1);
        i0 = irq;
        wr(OFS_IRQ_MASK, 32'h1);
        rd_chk("irq mask", OFS_IRQ_MASK, 32'h1);
        check("mask changes irq", i0 ^ irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h1);
        rd_chk("irq status cleared", OFS_IRQ_STATUS, 32'h0);
        check("irq low", irq, 1'b0);
        wb_xfer(1'b0, 16'h3FF0, 32'h0, 4'hF);
        check("unmapped err", er, 1'b1);
    endtask : t_irq

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_enable_regs();
        t_guard();
        t_ids();
        t_irq();
        print_verdict();
    end
endmodule : id_auth_and_flash_write_guard_tb_top
